/* pkg/link_port_pkg.sv */
// constants and carriers of the dual-channel fifo port and flag block
package link_port_pkg;
   localparam int NUM_CH = 2;
   localparam int ADDR_W = 5;
   localparam int FIFO_DEPTH = 64;
   localparam int PTR_W = 6;
   // register addresses
   localparam logic [ADDR_W-1:0] ADDR_PORT_A = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_PORT_B = 5'h01;
   localparam logic [ADDR_W-1:0] ADDR_INT_FLAGS = 5'h02;
   localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 5'h03;
   localparam logic [ADDR_W-1:0] ADDR_LEVEL_A = 5'h04;
   localparam logic [ADDR_W-1:0] ADDR_LEVEL_B = 5'h05;
   localparam logic [ADDR_W-1:0] ADDR_MSG_CTRL_A = 5'h0a;
   localparam logic [ADDR_W-1:0] ADDR_MSG_CTRL_B = 5'h0b;
   localparam logic [ADDR_W-1:0] ADDR_STATE_A = 5'h0c;
   localparam logic [ADDR_W-1:0] ADDR_STATE_B = 5'h0d;
   localparam logic [ADDR_W-1:0] ADDR_INDICATOR = 5'h0e;
   // interrupt flag bit positions
   localparam int BIT_STATUS = 7;
   localparam int BIT_WAKE = 6;
   localparam int BIT_TXF0 = 4;
   localparam int BIT_RXF0 = 2;
   localparam int BIT_RDY0 = 0;
   localparam logic [7:0] COR_MASK = 8'hfc;
   // control bit positions
   localparam int FRAMER_ON_BIT = 6;
   localparam int WHOLE_FRAME_BIT = 1;
   localparam int READY_PIN_EN0 = 0;
   localparam int FAULT_PIN_EN0 = 2;
   localparam int IND_STRIDE = 4;
   // reset values and pointer constants
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [PTR_W:0] PTR_ZERO = 7'h00;
   localparam logic [PTR_W:0] PTR_ONE = 7'h01;
   localparam logic [PTR_W:0] FIFO_FULL = 7'h40;

   typedef struct packed {
      logic rx_start;
      logic rx_push;
      logic [7:0] rx_data;
      logic rx_end;
      logic rx_ok;
      logic tx_pop;
      logic tx_fault;
      logic rx_fault;
   } chan_in_type;

   typedef struct packed {
      logic [7:0] tx_data;
      logic tx_valid;
      logic framer_on;
      logic whole_frame_mode;
      logic [7:0] rx_level;
   } chan_out_type;

   typedef struct packed {
      logic supply_err;
      logic thermal_err;
      logic sensor_supply_err;
      logic driver_err;
   } status_ev_type;
endpackage : link_port_pkg

/* verilog/fifo_port_flags.sv */
// dual-channel fifo data ports and shared interrupt flag register
`timescale 1ns/1ps
// Operation
// - channel port write pushes transmit fifo, read pops receive fifo
// - single and back-to-back burst port accesses are both served
// - fifos of a channel work only while its framer is on
// - flag register read clears bits 7..2, leaves bits 1..0
// - rx available flag clears when that channel's port is read
// - supply, thermal, sensor supply or driver fault sets status flag
// - wake sequence completion, good or bad, sets wake flag
// - transmitter fault of a channel sets its transmit fault flag
// - receive fault of a channel sets its receive fault flag
// - fault pin follows receive fault flag when its enable is set
// - default mode: rx available sets when fifo leaves empty
// - whole frame mode: rx available sets after a good full frame
// - ready pin follows rx available flag when its enable is set
// - interrupt output only from flags whose enable bit is one
// - count byte heads each frame, not counted in the level
module fifo_port_flags
   import link_port_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // register port from the serial front end
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // device events
   input wire status_ev_type status_ev_i,
   input wire logic wake_done_i,
   // framer side of each channel
   input wire chan_in_type [NUM_CH-1:0] chan_i,
   output chan_out_type [NUM_CH-1:0] chan_o,
   // request and indicator pins
   output logic irq_o,
   output logic chan_a_fault_indicator_pin_o,
   output logic chan_b_fault_indicator_pin_o,
   output logic chan_a_ready_indicator_pin_o,
   output logic chan_b_ready_indicator_pin_o
);
   // fifo storage; bit 8 marks a frame count byte
   logic [7:0] tx_mem [NUM_CH][FIFO_DEPTH];
   logic [8:0] rx_mem [NUM_CH][FIFO_DEPTH];
   // channel state
   logic [PTR_W:0] tx_wp [NUM_CH], next_tx_wp [NUM_CH];
   logic [PTR_W:0] tx_rp [NUM_CH], next_tx_rp [NUM_CH];
   logic [PTR_W:0] rx_wp [NUM_CH], next_rx_wp [NUM_CH];
   logic [PTR_W:0] rx_vp [NUM_CH], next_rx_vp [NUM_CH];
   logic [PTR_W:0] rx_rp [NUM_CH], next_rx_rp [NUM_CH];
   logic [PTR_W:0] rx_hp [NUM_CH], next_rx_hp [NUM_CH];
   logic [7:0] rx_cnt [NUM_CH], next_rx_cnt [NUM_CH];
   logic [7:0] rx_lvl [NUM_CH], next_rx_lvl [NUM_CH];
   logic in_frame [NUM_CH], next_in_frame [NUM_CH];
   logic [7:0] msg_ctrl [NUM_CH], next_msg_ctrl [NUM_CH];
   logic framer_on [NUM_CH], next_framer_on [NUM_CH];
   // shared registers
   logic [7:0] flags, next_flags;
   logic [7:0] int_en, next_int_en;
   logic [7:0] ind, next_ind;
   logic [7:0] next_rdata;
   logic [NUM_CH-1:0] fault_pin, next_fault_pin;
   logic [NUM_CH-1:0] ready_pin, next_ready_pin;
   // decoded strobes
   logic rd_port [NUM_CH], wr_port [NUM_CH];
   logic tx_push [NUM_CH], tx_pop [NUM_CH], rx_pop [NUM_CH];
   logic start_ok [NUM_CH], push_ok [NUM_CH], end_ok [NUM_CH];
   logic [7:0] rx_head [NUM_CH];
   logic [7:0] set_ev, clr_ev;

   function automatic logic [PTR_W:0] fill(input logic [PTR_W:0] wp,
                                          input logic [PTR_W:0] rp);
      return wp - rp;
   endfunction : fill

   function automatic logic [ADDR_W-1:0] chan_addr(
      input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b, input int c);
      return (c == 0) ? a : b;
   endfunction : chan_addr

   // both channels share one body so they stay identical
   always_comb begin
      set_ev = BYTE_ZERO;
      clr_ev = BYTE_ZERO;
      set_ev[BIT_STATUS] = |status_ev_i;
      set_ev[BIT_WAKE] = wake_done_i;
      for (int c = 0; c < NUM_CH; c++) begin
         wr_port[c] = reg_wr_i &&
            reg_addr_i == chan_addr(ADDR_PORT_A, ADDR_PORT_B, c);
         rd_port[c] = reg_rd_i &&
            reg_addr_i == chan_addr(ADDR_PORT_A, ADDR_PORT_B, c);
         // transmit side, gated by the framer enable
         tx_push[c] = wr_port[c] && framer_on[c] &&
            fill(tx_wp[c], tx_rp[c]) != FIFO_FULL;
         tx_pop[c] = chan_i[c].tx_pop && framer_on[c] &&
            tx_wp[c] != tx_rp[c];
         next_tx_wp[c] = tx_push[c] ? tx_wp[c] + PTR_ONE : tx_wp[c];
         next_tx_rp[c] = tx_pop[c] ? tx_rp[c] + PTR_ONE : tx_rp[c];
         // receive side; an empty read leaves the pointer alone
         rx_head[c] = rx_mem[c][rx_rp[c][PTR_W-1:0]][7:0];
         rx_pop[c] = rd_port[c] && framer_on[c] &&
            rx_rp[c] != rx_vp[c];
         start_ok[c] = framer_on[c] && chan_i[c].rx_start &&
            !in_frame[c] && fill(rx_wp[c], rx_rp[c]) != FIFO_FULL;
         push_ok[c] = framer_on[c] && in_frame[c] && chan_i[c].rx_push &&
            fill(rx_wp[c], rx_rp[c]) != FIFO_FULL;
         end_ok[c] = in_frame[c] && chan_i[c].rx_end;
         next_rx_wp[c] = rx_wp[c];
         next_rx_vp[c] = rx_vp[c];
         next_rx_rp[c] = rx_rp[c];
         next_rx_hp[c] = rx_hp[c];
         next_rx_cnt[c] = rx_cnt[c];
         next_rx_lvl[c] = rx_lvl[c];
         next_in_frame[c] = in_frame[c];
         // reserve the count byte slot at the head of the frame
         if (start_ok[c]) begin
            next_rx_hp[c] = rx_wp[c];
            next_rx_wp[c] = rx_wp[c] + PTR_ONE;
            next_rx_cnt[c] = BYTE_ZERO;
            next_in_frame[c] = 1'b1;
         end
         if (push_ok[c]) begin
            next_rx_wp[c] = rx_wp[c] + PTR_ONE;
            next_rx_cnt[c] = rx_cnt[c] + BYTE_ONE;
            next_rx_lvl[c] = rx_lvl[c] + BYTE_ONE;
            // default mode shows bytes as they arrive
            if (!msg_ctrl[c][WHOLE_FRAME_BIT]) begin
               next_rx_vp[c] = rx_wp[c] + PTR_ONE;
            end
         end
         // a bad frame is dropped in whole frame mode only
         if (end_ok[c]) begin
            next_in_frame[c] = 1'b0;
            if (!msg_ctrl[c][WHOLE_FRAME_BIT] || chan_i[c].rx_ok) begin
               next_rx_vp[c] = rx_wp[c];
            end else begin
               next_rx_wp[c] = rx_hp[c];
               next_rx_lvl[c] = rx_lvl[c] - rx_cnt[c];
            end
         end
         // the count byte does not lower the level
         if (rx_pop[c]) begin
            next_rx_rp[c] = rx_rp[c] + PTR_ONE;
            if (!rx_mem[c][rx_rp[c][PTR_W-1:0]][8]) begin
               next_rx_lvl[c] = next_rx_lvl[c] - BYTE_ONE;
            end
         end
         // flag sources of this channel
         set_ev[BIT_TXF0+c] = chan_i[c].tx_fault;
         set_ev[BIT_RXF0+c] = chan_i[c].rx_fault;
         if (msg_ctrl[c][WHOLE_FRAME_BIT]) begin
            set_ev[BIT_RDY0+c] = end_ok[c] && chan_i[c].rx_ok;
         end else begin
            set_ev[BIT_RDY0+c] = push_ok[c] && rx_vp[c] == rx_rp[c];
         end
         clr_ev[BIT_RDY0+c] = rd_port[c];
      end
      if (reg_rd_i && reg_addr_i == ADDR_INT_FLAGS) begin
         clr_ev = clr_ev | COR_MASK;
      end
      // set beats clear so an event in the read cycle is kept
      next_flags = (flags & ~clr_ev) | set_ev;
   end

   // control registers, read mux and pins
   always_comb begin
      next_int_en = int_en;
      next_ind = ind;
      next_rdata = reg_rdata_o;
      for (int c = 0; c < NUM_CH; c++) begin
         next_msg_ctrl[c] = msg_ctrl[c];
         next_framer_on[c] = framer_on[c];
         if (reg_wr_i && reg_addr_i ==
             chan_addr(ADDR_MSG_CTRL_A, ADDR_MSG_CTRL_B, c)) begin
            next_msg_ctrl[c] = reg_wdata_i;
         end
         if (reg_wr_i &&
             reg_addr_i == chan_addr(ADDR_STATE_A, ADDR_STATE_B, c)) begin
            next_framer_on[c] = reg_wdata_i[FRAMER_ON_BIT];
         end
      end
      if (reg_wr_i && reg_addr_i == ADDR_INT_ENABLE) begin
         next_int_en = reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == ADDR_INDICATOR) begin
         next_ind = reg_wdata_i;
      end
      // the fault and ready pins track the enable written this cycle
      for (int c = 0; c < NUM_CH; c++) begin
         next_fault_pin[c] = next_ind[FAULT_PIN_EN0+IND_STRIDE*c] &&
            next_flags[BIT_RXF0+c];
         next_ready_pin[c] = next_ind[READY_PIN_EN0+IND_STRIDE*c] &&
            next_flags[BIT_RDY0+c];
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            ADDR_PORT_A: next_rdata = framer_on[0] ? rx_head[0] : BYTE_ZERO;
            ADDR_PORT_B: next_rdata = framer_on[1] ? rx_head[1] : BYTE_ZERO;
            ADDR_INT_FLAGS: next_rdata = flags;
            ADDR_INT_ENABLE: next_rdata = int_en;
            ADDR_LEVEL_A: next_rdata = rx_lvl[0];
            ADDR_LEVEL_B: next_rdata = rx_lvl[1];
            ADDR_MSG_CTRL_A: next_rdata = msg_ctrl[0];
            ADDR_MSG_CTRL_B: next_rdata = msg_ctrl[1];
            ADDR_STATE_A: next_rdata = BYTE_ZERO | (8'(framer_on[0])
                                         << FRAMER_ON_BIT);
            ADDR_STATE_B: next_rdata = BYTE_ZERO | (8'(framer_on[1])
                                         << FRAMER_ON_BIT);
            ADDR_INDICATOR: next_rdata = ind;
            default: next_rdata = BYTE_ZERO;
         endcase
      end
   end

   // state registers
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            tx_wp[c] <= PTR_ZERO;
            tx_rp[c] <= PTR_ZERO;
            rx_wp[c] <= PTR_ZERO;
            rx_vp[c] <= PTR_ZERO;
            rx_rp[c] <= PTR_ZERO;
            rx_hp[c] <= PTR_ZERO;
            rx_cnt[c] <= BYTE_ZERO;
            rx_lvl[c] <= BYTE_ZERO;
            in_frame[c] <= 1'b0;
            msg_ctrl[c] <= BYTE_ZERO;
            framer_on[c] <= 1'b0;
         end
         flags <= BYTE_ZERO;
         int_en <= BYTE_ZERO;
         ind <= BYTE_ZERO;
         reg_rdata_o <= BYTE_ZERO;
         fault_pin <= '0;
         ready_pin <= '0;
      end else begin
         tx_wp <= next_tx_wp;
         tx_rp <= next_tx_rp;
         rx_wp <= next_rx_wp;
         rx_vp <= next_rx_vp;
         rx_rp <= next_rx_rp;
         rx_hp <= next_rx_hp;
         rx_cnt <= next_rx_cnt;
         rx_lvl <= next_rx_lvl;
         in_frame <= next_in_frame;
         msg_ctrl <= next_msg_ctrl;
         framer_on <= next_framer_on;
         flags <= next_flags;
         int_en <= next_int_en;
         ind <= next_ind;
         reg_rdata_o <= next_rdata;
         fault_pin <= next_fault_pin;
         ready_pin <= next_ready_pin;
      end
   end

   // fifo storage has no reset; contents are don't care until written
   always_ff @(posedge clk_sys_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (tx_push[c]) begin
            tx_mem[c][tx_wp[c][PTR_W-1:0]] <= reg_wdata_i;
         end
         if (push_ok[c]) begin
            rx_mem[c][rx_wp[c][PTR_W-1:0]] <= {1'b0, chan_i[c].rx_data};
         end
         if (end_ok[c]) begin
            rx_mem[c][rx_hp[c][PTR_W-1:0]] <= {1'b1, rx_cnt[c]};
         end
      end
   end

   // outputs; the request is masked per flag
   always_comb begin
      irq_o = |(flags & int_en);
      chan_a_fault_indicator_pin_o = fault_pin[0];
      chan_b_fault_indicator_pin_o = fault_pin[1];
      chan_a_ready_indicator_pin_o = ready_pin[0];
      chan_b_ready_indicator_pin_o = ready_pin[1];
      for (int c = 0; c < NUM_CH; c++) begin
         chan_o[c].tx_data = tx_mem[c][tx_rp[c][PTR_W-1:0]];
         chan_o[c].tx_valid = framer_on[c] && tx_wp[c] != tx_rp[c];
         chan_o[c].framer_on = framer_on[c];
         chan_o[c].whole_frame_mode = msg_ctrl[c][WHOLE_FRAME_BIT];
         chan_o[c].rx_level = rx_lvl[c];
      end
   end

   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   logic int_rd;
   logic [7:0] low_flags;
   assign int_rd = reg_rd_i && reg_addr_i == ADDR_INT_FLAGS;
   assign low_flags = flags & ~COR_MASK;

   sequence s_quiet_int_read;
      int_rd && (set_ev & COR_MASK) == BYTE_ZERO;
   endsequence
   property p_cor_clear;
      s_quiet_int_read |=> (flags & COR_MASK) == BYTE_ZERO;
   endproperty
   a_cor_clear: assert property (p_cor_clear)
      else $error("flag read did not clear bits 7..2");
   property p_low_keep;
      int_rd && !rd_port[0] && !rd_port[1] &&
         set_ev[BIT_RDY0+1:BIT_RDY0] == 2'b00 |=> $stable(low_flags);
   endproperty
   a_low_keep: assert property (p_low_keep)
      else $error("flag read changed bits 1..0");
   property p_set_wins;
      int_rd |=> (flags & $past(set_ev) & COR_MASK) ==
         ($past(set_ev) & COR_MASK);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost in clearing read cycle");
   property p_status;
      (|status_ev_i) |=> flags[BIT_STATUS];
   endproperty
   a_status: assert property (p_status)
      else $error("status fault did not set status flag");
   property p_wake;
      wake_done_i |=> flags[BIT_WAKE] ##1 (flags[BIT_WAKE] || $past(int_rd));
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake completion flag missing");
   // an enabled event must reach the request on the next cycle
   property p_irq;
      (set_ev & next_int_en) != BYTE_ZERO |=> irq_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("enabled flag did not raise the request");

   for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
      sequence s_two_pops;
         rx_pop[g] ##1 rx_pop[g];
      endsequence
      property p_tx_fault;
         chan_i[g].tx_fault |=> flags[BIT_TXF0+g];
      endproperty
      a_tx_fault: assert property (p_tx_fault)
         else $error("transmit fault flag not set");
      property p_rx_fault;
         chan_i[g].rx_fault |=> flags[BIT_RXF0+g];
      endproperty
      a_rx_fault: assert property (p_rx_fault)
         else $error("receive fault flag not set");
      property p_fault_pin;
         fault_pin[g] == (ind[FAULT_PIN_EN0+IND_STRIDE*g] &&
                          flags[BIT_RXF0+g]);
      endproperty
      a_fault_pin: assert property (p_fault_pin)
         else $error("fault pin does not follow its flag");
      property p_ready_pin;
         ready_pin[g] == (ind[READY_PIN_EN0+IND_STRIDE*g] &&
                          flags[BIT_RDY0+g]);
      endproperty
      a_ready_pin: assert property (p_ready_pin)
         else $error("ready pin does not follow its flag");
      property p_rdy_clear;
         rd_port[g] && !set_ev[BIT_RDY0+g] |=> !flags[BIT_RDY0+g];
      endproperty
      a_rdy_clear: assert property (p_rdy_clear)
         else $error("port read did not clear rx available");
      property p_burst;
         s_two_pops |=> rx_rp[g] == $past(rx_rp[g], 2) + 7'h02;
      endproperty
      a_burst: assert property (p_burst)
         else $error("burst read did not pop two bytes");
      property p_tx_push;
         tx_push[g] && !tx_pop[g] |=>
            fill(tx_wp[g], tx_rp[g]) == fill($past(tx_wp[g]),
                                             $past(tx_rp[g])) + PTR_ONE;
      endproperty
      a_tx_push: assert property (p_tx_push)
         else $error("port write did not enter transmit fifo");
      property p_gate;
         !framer_on[g] |-> !chan_o[g].tx_valid && !rx_pop[g] && !tx_push[g];
      endproperty
      a_gate: assert property (p_gate)
         else $error("fifo used while framer off");
   end
endmodule : fifo_port_flags

/* bench/host_port_model.sv */
// host register port model standing for the serial master
`timescale 1ns/1ps
module host_port_model
   import link_port_pkg::*;
(
   // clock
   input wire logic clk_sys_i,
   // register port towards the device
   output logic reg_rd_o,
   output logic reg_wr_o,
   output logic [ADDR_W-1:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i
);
   // idle at time zero, strobes low
   initial begin
      reg_rd_o = 1'b0;
      reg_wr_o = 1'b0;
      reg_addr_o = 5'h1f;
      reg_wdata_o = 8'h5a;
   end

   // one byte access; caller sits just after a rising edge
   // hold keeps the strobe up so the next call forms a burst
   task automatic access(input logic w, input logic [ADDR_W-1:0] a,
         input logic [7:0] d, input bit hold, output logic [7:0] q);
      reg_wr_o = w;
      reg_rd_o = ~w;
      reg_addr_o = a;
      reg_wdata_o = d;
      @(posedge clk_sys_i);
      #1;
      q = reg_rdata_i;
      if (!hold) begin
         // released lines show the inverse, so stale values never match
         reg_wr_o = 1'b0;
         reg_rd_o = 1'b0;
         reg_addr_o = ~a;
         reg_wdata_o = ~d;
         // one idle edge so the next call never flips a strobe in place
         @(posedge clk_sys_i);
         #1;
      end
   endtask : access
endmodule : host_port_model

/* bench/dual_channel_fifo_port_and_irq_flags_bench.sv */
// self-checking bench of the fifo port and flag block
`timescale 1ns/1ps
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin \
   num_errors++; $display("MISMATCH %0t %s", $time, m); end end
module dual_channel_fifo_port_and_irq_flags_bench
   import link_port_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic reg_rd, reg_wr, irq, fault_a, fault_b, ready_a, ready_b;
   logic [ADDR_W-1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, q;
   status_ev_type status_ev = '0;
   logic wake_done = 1'b0;
   chan_in_type [NUM_CH-1:0] chan_in = '0;
   chan_out_type [NUM_CH-1:0] chan_out;
   int num_errors = 0;
   int compares = 0;
   int ev_bit[9] = '{7, 7, 7, 7, 6, 4, 5, 2, 3};

   always #10 clk_sys_i = ~clk_sys_i;

   fifo_port_flags i_fifo_port_flags (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .reg_rd_i(reg_rd), .reg_wr_i(reg_wr), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
      .status_ev_i(status_ev), .wake_done_i(wake_done), .chan_i(chan_in),
      .chan_o(chan_out), .irq_o(irq),
      .chan_a_fault_indicator_pin_o(fault_a),
      .chan_b_fault_indicator_pin_o(fault_b),
      .chan_a_ready_indicator_pin_o(ready_a),
      .chan_b_ready_indicator_pin_o(ready_b));

   host_port_model i_host_port_model (.clk_sys_i(clk_sys_i),
      .reg_rd_o(reg_rd), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr),
      .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

   // all bench waits but the hang guard land 1 ns after an edge
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         #1;
      end
   endtask : cyc

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [7:0] x;
      i_host_port_model.access(1'b1, a, d, 1'b0, x);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] r);
      i_host_port_model.access(1'b0, a, 8'h00, 1'b0, r);
   endtask : rd

   // start, n pushes, end with the given outcome
   task automatic frame(input int ch, input int n, input logic [7:0] base,
         input logic ok);
      chan_in[ch].rx_start = 1'b1;
      cyc(1);
      chan_in[ch].rx_start = 1'b0;
      for (int i = 0; i < n; i++) begin
         chan_in[ch].rx_push = 1'b1;
         chan_in[ch].rx_data = base + 8'(i);
         cyc(1);
      end
      chan_in[ch].rx_push = 1'b0;
      chan_in[ch].rx_end = 1'b1;
      chan_in[ch].rx_ok = ok;
      cyc(1);
      chan_in[ch].rx_end = 1'b0;
   endtask : frame

   // raise event source k, or drop all of them for k below zero
   task automatic set_ev(input int k);
      status_ev = (k >= 0 && k < 4) ? 4'(8 >> k) : 4'h0;
      wake_done = (k == 4);
      chan_in[0].tx_fault = (k == 5);
      chan_in[1].tx_fault = (k == 6);
      chan_in[0].rx_fault = (k == 7);
      chan_in[1].rx_fault = (k == 8);
   endtask : set_ev

   task automatic t_tx();
      rd(ADDR_PORT_B, q);
      `CHK(q, 8'h00, "port b read while off")
      wr(ADDR_PORT_B, 8'h77);
      `CHK(chan_out[1].tx_valid, 1'b0, "tx b accepted while off")
      wr(ADDR_STATE_A, 8'h40);
      `CHK(chan_out[0].framer_on, 1'b1, "framer a off")
      for (int i = 0; i < 3; i++)
         i_host_port_model.access(1'b1, ADDR_PORT_A, 8'ha0 + 8'(i), i < 2, q);
      `CHK(chan_out[0].tx_valid, 1'b1, "tx a not valid")
      `CHK(chan_out[0].tx_data, 8'ha0, "tx a head")
      chan_in[0].tx_pop = 1'b1;
      cyc(1);
      `CHK(chan_out[0].tx_data, 8'ha1, "tx a second")
      cyc(2);
      chan_in[0].tx_pop = 1'b0;
      `CHK(chan_out[0].tx_valid, 1'b0, "tx a not drained")
   endtask : t_tx

   task automatic t_rx_default();
      wr(ADDR_INDICATOR, 8'h01);
      frame(0, 2, 8'h30, 1'b1);
      rd(ADDR_INT_FLAGS, q);
      `CHK(q[0], 1'b1, "rx a ready not set")
      `CHK(ready_a, 1'b1, "ready pin a low")
      rd(ADDR_INT_FLAGS, q);
      `CHK(q[0], 1'b1, "ready a cleared by flag read")
      rd(ADDR_LEVEL_A, q);
      `CHK(q, 8'h02, "level a")
      `CHK(chan_out[0].rx_level, 8'h02, "level a out")
      // read count byte plus message bytes only, never past empty
      for (int i = 0; i < 3; i++) begin
         i_host_port_model.access(1'b0, ADDR_PORT_A, 8'h00, i < 2, q);
         `CHK(q, (i == 0) ? 8'h02 : 8'h30 + 8'(i - 1), "rx a")
      end
      rd(ADDR_INT_FLAGS, q);
      `CHK(q[0], 1'b0, "ready a kept after port read")
      `CHK(ready_a, 1'b0, "ready pin a stuck")
   endtask : t_rx_default

   task automatic t_rx_whole();
      wr(ADDR_STATE_B, 8'h40);
      wr(ADDR_MSG_CTRL_B, 8'h02);
      wr(ADDR_INDICATOR, 8'h10);
      `CHK(chan_out[1].whole_frame_mode, 1'b1, "whole mode b off")
      frame(1, 1, 8'h55, 1'b0);
      rd(ADDR_INT_FLAGS, q);
      `CHK(q[1], 1'b0, "bad frame flagged")
      `CHK(ready_b, 1'b0, "ready pin b on bad frame")
      rd(ADDR_LEVEL_B, q);
      `CHK(q, 8'h00, "bad frame kept")
      frame(1, 1, 8'h66, 1'b1);
      rd(ADDR_INT_FLAGS, q);
      `CHK(q[1], 1'b1, "good frame not flagged")
      `CHK(ready_b, 1'b1, "ready pin b low")
      `CHK(chan_out[1].rx_level, 8'h01, "level b out")
      rd(ADDR_PORT_B, q);
      `CHK(q, 8'h01, "count byte b")
      rd(ADDR_PORT_B, q);
      `CHK(q, 8'h66, "data byte b")
      `CHK(ready_b, 1'b0, "ready pin b stuck")
   endtask : t_rx_whole

   task automatic t_events();
      wr(ADDR_INDICATOR, 8'h44);
      for (int k = 0; k < 9; k++) begin
         wr(ADDR_INT_ENABLE, 8'h00);
         set_ev(k);
         cyc(1);
         set_ev(-1);
         `CHK(irq, 1'b0, "masked request")
         wr(ADDR_INT_ENABLE, 8'(1 << ev_bit[k]));
         `CHK(irq, 1'b1, "enabled request")
         `CHK(fault_a, (k == 7), "fault pin a")
         `CHK(fault_b, (k == 8), "fault pin b")
         rd(ADDR_INT_FLAGS, q);
         `CHK(q & COR_MASK, 8'(1 << ev_bit[k]), "ev flag")
         rd(ADDR_INT_FLAGS, q);
         `CHK(q & COR_MASK, 8'h00, "flag not cleared")
      end
      // event in the very cycle of the clearing read, request enabled;
      // the strobe is held so the event drops before the second read
      wr(ADDR_INT_ENABLE, 8'(1 << BIT_WAKE));
      set_ev(4);
      i_host_port_model.access(1'b0, ADDR_INT_FLAGS, 8'h00, 1'b1, q);
      set_ev(-1);
      rd(ADDR_INT_FLAGS, q);
      `CHK(q[BIT_WAKE], 1'b1, "event lost in read cycle")
      `CHK(irq, 1'b0, "request kept after clear")
   endtask : t_events

   task automatic report_and_stop();
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop

   // hang guard
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      num_errors++;
      $display("MISMATCH %0t run too long", $time);
      report_and_stop();
   end

   initial begin
      repeat (12) @(posedge clk_sys_i);
      #1;
      rst_i = 1'b0;
      rd(ADDR_INT_FLAGS, q);
      `CHK(q, 8'h00, "flags after reset")
      t_tx();
      t_rx_default();
      t_rx_whole();
      t_events();
      report_and_stop();
   end
endmodule : dual_channel_fifo_port_and_irq_flags_bench
